// ===== verilog/obsp_slave.sv
/*
 * obsp_slave: slave end of the bus port. a small register array answers
 * zero-wait reads combinationally and takes single-cycle writes.
 * assumes: interconnect drives address/strobes registered, select combinational.
 */
`timescale 1ns/1ps
// Notes on behaviour
// - all transfers synchronous to the single clock
// - ignore every input unless selected
// - interconnect supplies 1..32 bit address; this slave refuses ADDR_W above 12
// - begin marker only in first cycle
// - byte-lane mask 0, 2 or 4 bits
// - read strobe and read data together
// - write strobe and write data together
// - read-valid only for variable latency slaves
// - stall output when cannot answer immediately
// - streaming ready-for-data output
// - streaming data-available output
// - streaming end-of-packet output
// - interrupt asserted when service needed
// - reset request resets whole system
// - read, write, byte strobes active low
// - tolerate back-to-back select and read held
// - read starts one edge, ends next, zero wait
// - read data combinational from addressed location
// - interconnect presents address then combinational select
// - interconnect samples read data next edge
// - full width word, no latency
// - never start on select or strobe edges
// - outputs may be undefined while unselected
module obsp_slave #(
    parameter int ADDR_W = obsp_pkg::ADDR_W_DEF,
    parameter int DATA_W = obsp_pkg::DATA_W_DEF,
    parameter int BE_W   = obsp_pkg::BE_W_DEF
) (
    // clock and reset
    input  wire logic  clock,
    input  wire logic  reset,
    // bus side
    obsp_if.slv        bus,
    // user side
    input  wire logic  irq_set,
    input  wire logic  irq_clear,
    input  wire logic  sys_reset_ask,
    output logic       last_write_pulse,
    output logic [DATA_W-1:0] reg0_value
);
    localparam int DEPTH = 1 << ADDR_W;

    // elaboration checks: refuse sizes the array or the lanes cannot serve
    if (ADDR_W < 1 || ADDR_W > obsp_pkg::ADDR_W_MAX) begin : g_bad_addr
        $error("bad ADDR_W");
    end
    // the word array is built from flops, so deep maps are refused
    if (ADDR_W > 12) begin : g_too_deep
        $error("ADDR_W too deep for flop array");
    end
    if (DATA_W < 1 || DATA_W > obsp_pkg::DATA_W_MAX) begin : g_bad_data
        $error("bad DATA_W");
    end
    if (!(BE_W == 0 || BE_W == 2 || BE_W == 4)) begin : g_bad_be
        $error("bad BE_W");
    end
    if (BE_W != 0 && BE_W * obsp_pkg::BYTE_W != DATA_W) begin : g_be_mismatch
        $error("BE_W mismatch");
    end

    typedef struct packed {
        logic [DEPTH-1:0][DATA_W-1:0] mem;
        logic                         irq;
        logic                         reset_req;
        logic                         wr_pulse;
    } obsp_slv_state_t;

    obsp_slv_state_t st_r;
    obsp_slv_state_t st_nxt;

    // one decode shared by the read path and the write merge
    function automatic logic [DATA_W-1:0] word_at(input obsp_slv_state_t s,
                                                  input logic [ADDR_W-1:0] a);
        return s.mem[a];
    endfunction : word_at

    function automatic logic [DATA_W-1:0] lane_merge(input logic [DATA_W-1:0] old_v,
                                                     input logic [DATA_W-1:0] new_v,
                                                     input logic [BE_W-1:0]   be_n);
        logic [DATA_W-1:0] res;
        res = new_v;
        for (int i = 0; i < BE_W; i++) begin
            if (be_n[i] != obsp_pkg::STROBE_ON) begin
                res[i*obsp_pkg::BYTE_W +: obsp_pkg::BYTE_W] =
                    old_v[i*obsp_pkg::BYTE_W +: obsp_pkg::BYTE_W];
            end
        end
        return res;
    endfunction : lane_merge

    logic wr_take;
    // level-sampled strobes every edge, no edge detection on select or strobe
    assign wr_take = bus.chip_sel && (bus.write_n == obsp_pkg::STROBE_ON);

    always_comb begin
        st_nxt = st_r;
        st_nxt.wr_pulse = 1'b0;
        if (wr_take) begin
            st_nxt.mem[bus.address] = lane_merge(word_at(st_r, bus.address), bus.write_data,
                                                 bus.byte_en_n);
            st_nxt.wr_pulse = 1'b1;
        end
        // set wins over clear
        if (irq_clear) st_nxt.irq = 1'b0;
        if (irq_set) st_nxt.irq = 1'b1;
        st_nxt.reset_req = sys_reset_ask;
        if (reset) begin
            st_nxt.mem       = '0;
            st_nxt.irq       = obsp_pkg::FLAG_RST;
            st_nxt.reset_req = obsp_pkg::FLAG_RST;
            st_nxt.wr_pulse  = 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        st_r <= st_nxt;
    end

    // zero-wait read: whole word straight from the array, held while selected
    // so back-to-back reads just follow the address
    always_comb begin
        bus.read_data = '0;
        if (bus.chip_sel && bus.read_n == obsp_pkg::STROBE_ON) begin
            bus.read_data = word_at(st_r, bus.address);
        end
    end

    // fixed zero latency: no stall, no read-valid; no streaming data path
    assign bus.read_valid     = 1'b0;
    assign bus.wait_req       = 1'b0;
    assign bus.ready_for_data = 1'b0;
    assign bus.data_avail     = 1'b0;
    assign bus.end_of_packet  = 1'b0;
    assign bus.irq            = st_r.irq;
    assign bus.reset_req      = st_r.reset_req;

    assign last_write_pulse = st_r.wr_pulse;
    assign reg0_value       = st_r.mem[0];
endmodule : obsp_slave

// ===== verilog/obsp_pkg.sv
/*
 * obsp_pkg: shared widths, polarity levels and reset values for the
 * on-chip bus slave port (read path) and its interconnect end.
 * assumes: one global clock, synchronous active-high reset.
 */
package obsp_pkg;
    localparam int ADDR_W_DEF  = 4;
    localparam int DATA_W_DEF  = 32;
    localparam int BE_W_DEF    = 4;
    localparam int ADDR_W_MAX  = 32;
    localparam int DATA_W_MAX  = 32;
    // active-low strobes: asserted level
    localparam logic STROBE_ON  = 1'b0;
    localparam logic STROBE_OFF = 1'b1;
    localparam logic FLAG_RST   = 1'b0;
    localparam int   BYTE_W     = 8;
endpackage : obsp_pkg

// ===== verilog/obsp_if.sv
/*
 * obsp_if: slave port signal set between the interconnect and a slave.
 * assumes: both ends clocked by the same global clock outside.
 */
`timescale 1ns/1ps
interface obsp_if #(
    parameter int ADDR_W = obsp_pkg::ADDR_W_DEF,
    parameter int DATA_W = obsp_pkg::DATA_W_DEF,
    parameter int BE_W   = obsp_pkg::BE_W_DEF
);
    logic              chip_sel;
    logic [ADDR_W-1:0] address;
    logic              begin_xfer;
    logic [BE_W-1:0]   byte_en_n;
    logic              read_n;
    logic [DATA_W-1:0] read_data;
    logic              write_n;
    logic [DATA_W-1:0] write_data;
    logic              read_valid;
    logic              wait_req;
    logic              ready_for_data;
    logic              data_avail;
    logic              end_of_packet;
    logic              irq;
    logic              reset_req;

    modport ic (
        output chip_sel, address, begin_xfer, byte_en_n, read_n, write_n, write_data,
        input  read_data, read_valid, wait_req, ready_for_data, data_avail,
               end_of_packet, irq, reset_req
    );
    modport slv (
        input  chip_sel, address, begin_xfer, byte_en_n, read_n, write_n, write_data,
        output read_data, read_valid, wait_req, ready_for_data, data_avail,
               end_of_packet, irq, reset_req
    );
endinterface : obsp_if

// ===== verilog/obsp_ic.sv
/*
 * obsp_ic: interconnect end. takes a read or write command, registers
 * address and strobes, decodes select combinationally, captures read data
 * on the following edge.
 * assumes: one slave mapped at base BASE, same clock as the slave.
 */
`timescale 1ns/1ps
module obsp_ic #(
    parameter int ADDR_W = obsp_pkg::ADDR_W_DEF,
    parameter int DATA_W = obsp_pkg::DATA_W_DEF,
    parameter int BE_W   = obsp_pkg::BE_W_DEF,
    parameter int SYS_W  = 8,
    parameter logic [SYS_W-1:0] BASE = 8'h00
) (
    // clock and reset
    input  wire logic              clock,
    input  wire logic              reset,
    // command side
    input  wire logic              cmd_valid,
    input  wire logic              cmd_write,
    input  wire logic [SYS_W-1:0]  cmd_addr,
    input  wire logic [BE_W-1:0]   cmd_be,
    input  wire logic [DATA_W-1:0] cmd_wdata,
    output logic                   rsp_valid,
    output logic [DATA_W-1:0]      rsp_data,
    // bus side
    obsp_if.ic                     bus
);
    // at least one address bit must be left over for the base decode
    if (ADDR_W < 1 || ADDR_W >= SYS_W) begin : g_bad_addr
        $error("bad ADDR_W");
    end

    typedef struct packed {
        logic              act;
        logic              wr;
        logic [SYS_W-1:0]  addr;
        logic [BE_W-1:0]   be_n;
        logic [DATA_W-1:0] wdata;
        logic              rsp;
        logic [DATA_W-1:0] rdata;
    } obsp_ic_state_t;

    obsp_ic_state_t st_r;
    obsp_ic_state_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        st_nxt.rsp = 1'b0;
        // capture on the edge after the cycle opened
        if (st_r.act && !st_r.wr) begin
            st_nxt.rdata = bus.read_data;
            st_nxt.rsp   = 1'b1;
        end
        st_nxt.act = cmd_valid;
        if (cmd_valid) begin
            st_nxt.wr    = cmd_write;
            st_nxt.addr  = cmd_addr;
            st_nxt.be_n  = ~cmd_be;
            st_nxt.wdata = cmd_wdata;
        end
        if (reset) begin
            st_nxt = '0;
        end
    end

    always_ff @(posedge clock) begin
        st_r <= st_nxt;
    end

    // combinational select from the registered address
    assign bus.chip_sel   = st_r.act &&
                            (st_r.addr[SYS_W-1:ADDR_W] == BASE[SYS_W-1:ADDR_W]);
    assign bus.address    = st_r.addr[ADDR_W-1:0];
    assign bus.begin_xfer = st_r.act;
    assign bus.byte_en_n  = st_r.be_n;
    assign bus.read_n     = (st_r.act && !st_r.wr) ? obsp_pkg::STROBE_ON
                                                   : obsp_pkg::STROBE_OFF;
    assign bus.write_n    = (st_r.act && st_r.wr) ? obsp_pkg::STROBE_ON
                                                  : obsp_pkg::STROBE_OFF;
    assign bus.write_data = st_r.wdata;

    assign rsp_valid = st_r.rsp;
    assign rsp_data  = st_r.rdata;
endmodule : obsp_ic

// ===== bench/obsp_slave_assertions.sv
/* obsp_checker: concurrent checks on the slave port signals.
   assumes: one clock, sync high reset, placed beside obsp_if. */
`timescale 1ns/1ps
module obsp_checker #(
    parameter int ADDR_W = 4,
    parameter int DATA_W = 32,
    parameter int BE_W   = 4
) (
    // clock and reset
    input wire logic              clock,
    input wire logic              reset,
    // interconnect to slave
    input wire logic              chip_sel,
    input wire logic [ADDR_W-1:0] address,
    input wire logic              begin_xfer,
    input wire logic [BE_W-1:0]   byte_en_n,
    input wire logic              read_n,
    input wire logic              write_n,
    input wire logic [DATA_W-1:0] write_data,
    // slave to interconnect
    input wire logic [DATA_W-1:0] read_data,
    input wire logic              read_valid,
    input wire logic              wait_req,
    input wire logic              ready_for_data,
    input wire logic              data_avail,
    input wire logic              end_of_packet,
    input wire logic              irq,
    input wire logic              reset_req
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);
    sequence s_rd;
        chip_sel && !read_n;
    endsequence
    sequence s_full_wr;
        chip_sel && !write_n && byte_en_n == '0;
    endsequence
    property p_quiet; $fell(reset) |-> !irq && !reset_req && read_n && write_n; endproperty
    a_quiet: assert property (p_quiet) else $error("outputs busy after reset");
    property p_no_stall; !wait_req; endproperty
    a_no_stall: assert property (p_no_stall) else $error("stall raised");
    property p_no_lat; !read_valid; endproperty
    a_no_lat: assert property (p_no_lat) else $error("read valid raised");
    property p_stream; !ready_for_data && !data_avail && !end_of_packet; endproperty
    a_stream: assert property (p_stream) else $error("stream flag raised");
    property p_unsel; !(chip_sel && !read_n) |-> read_data == '0; endproperty
    a_unsel: assert property (p_unsel) else $error("data while unselected");
    property p_begin; begin_xfer == (!read_n || !write_n); endproperty
    a_begin: assert property (p_begin) else $error("begin marker off");
    property p_one_dir; read_n || write_n; endproperty
    a_one_dir: assert property (p_one_dir) else $error("read and write together");
    property p_rd_hold;
        s_rd ##1 (chip_sel && !read_n && $stable(address)) |-> $stable(read_data);
    endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("held read changed");
    property p_wr_rd;
        s_full_wr ##1 (chip_sel && !read_n && address == $past(address))
            |-> read_data == $past(write_data);
    endproperty
    a_wr_rd: assert property (p_wr_rd) else $error("read after write wrong");
endmodule : obsp_checker

// ===== bench/onchip_bus_slave_port_read_bench.sv
/* onchip_bus_slave_port_read_bench: interconnect and slave face to face,
   random commands against a word model. assumes: 4-bit word address. */
`timescale 1ns/1ps
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin err_total++; \
    $display("ERROR %s expected %h seen %h", n, e, s); end end
module onchip_bus_slave_port_read_bench;
    logic        clock = 0, reset = 1, cmd_valid = 0, cmd_write = 0;
    logic [7:0]  cmd_addr = '0;
    logic [3:0]  cmd_be = '0;
    logic [31:0] cmd_wdata = '0, rsp_data, reg0_value, rnd = 32'h0000_92a8;
    logic        rsp_valid, irq_set = 0, irq_clear = 0, sys_reset_ask = 0, last_write_pulse;
    logic [31:0] mem [16];
    logic [31:0] exp_q [$];
    logic [31:0] exp_word;
    int          err_total = 0, check_count = 0, wr_exp = 0, wr_seen = 0;
    obsp_if bus ();
    obsp_ic obsp_ic_i (.clock(clock), .reset(reset), .cmd_valid(cmd_valid),
        .cmd_write(cmd_write), .cmd_addr(cmd_addr), .cmd_be(cmd_be), .cmd_wdata(cmd_wdata),
        .rsp_valid(rsp_valid), .rsp_data(rsp_data), .bus(bus));
    obsp_slave obsp_slave_i (.clock(clock), .reset(reset), .bus(bus), .irq_set(irq_set),
        .irq_clear(irq_clear), .sys_reset_ask(sys_reset_ask),
        .last_write_pulse(last_write_pulse), .reg0_value(reg0_value));
    obsp_checker obsp_checker_i (.clock(clock), .reset(reset), .chip_sel(bus.chip_sel),
        .address(bus.address), .begin_xfer(bus.begin_xfer), .byte_en_n(bus.byte_en_n),
        .read_n(bus.read_n), .write_n(bus.write_n), .write_data(bus.write_data),
        .read_data(bus.read_data), .read_valid(bus.read_valid), .wait_req(bus.wait_req),
        .ready_for_data(bus.ready_for_data), .data_avail(bus.data_avail),
        .end_of_packet(bus.end_of_packet), .irq(bus.irq), .reset_req(bus.reset_req));
    initial forever #4 clock = ~clock;
    always @(posedge clock) begin
        if (last_write_pulse === 1'b1) wr_seen++;
        if (rsp_valid === 1'b1) begin
            if (exp_q.size() == 0) `CHK("rsp_spare", 1'b0, 1'b1)
            else begin
                exp_word = exp_q.pop_front();
                `CHK("rsp_data", exp_word, rsp_data)
            end
        end
    end
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], 1'b0} ^ (x[31] ? 32'h8020_0003 : 32'h0000_0000);
    endfunction : lfsr
    task automatic do_reset;
        @(posedge clock) reset <= 1;
        repeat (12) @(posedge clock);
        reset <= 0;
        foreach (mem[i]) mem[i] = '0;
    endtask : do_reset
    task automatic issue(input logic w, input logic [7:0] a, input logic [3:0] be,
                         input logic [31:0] d);
        @(posedge clock);
        cmd_valid <= 1; cmd_write <= w; cmd_addr <= a; cmd_be <= be; cmd_wdata <= d;
        if (w && a[7:4] == 4'h0) begin
            wr_exp++;
            for (int i = 0; i < 4; i++) if (be[i]) mem[a[3:0]][i*8 +: 8] = d[i*8 +: 8];
        end
        if (!w) exp_q.push_back(a[7:4] == 4'h0 ? mem[a[3:0]] : 32'h0000_0000);
    endtask : issue
    task automatic drain;
        @(posedge clock) cmd_valid <= 0;
        for (int i = 0; i < 10 && exp_q.size() != 0; i++) @(posedge clock);
        // let a trailing write reach its pulse and the word array
        repeat (3) @(posedge clock);
        #1 `CHK("drain", 0, exp_q.size())
    endtask : drain
    task automatic flag(input logic s, input logic c, input logic e);
        @(posedge clock) irq_set <= s; irq_clear <= c;
        @(posedge clock) irq_set <= 0; irq_clear <= 0;
        @(posedge clock) #1 `CHK("irq", e, bus.irq)
    endtask : flag
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : tally_and_finish
    initial begin
        do_reset();
        for (int n = 0; n < 300; n++) begin
            rnd = lfsr(rnd);
            issue(rnd[20], {3'h0, rnd[8] & rnd[9], rnd[3:0]}, rnd[15:12] | {3'h0, rnd[21]}, rnd);
            if (rnd[22] && rnd[23]) issue(1'b0, {4'h0, rnd[3:0]}, 4'hf, 0);
        end
        drain();
        `CHK("write_count", wr_exp, wr_seen)
        `CHK("reg0", mem[0], reg0_value)
        $display("test random traffic done");
        flag(1, 0, 1); flag(0, 1, 0); flag(1, 1, 1);
        $display("test interrupt done");
        @(posedge clock) sys_reset_ask <= 1;
        @(posedge clock) sys_reset_ask <= 0;
        #1 `CHK("reset_req", 1'b1, bus.reset_req)
        @(posedge clock) #1 `CHK("reset_req_off", 1'b0, bus.reset_req)
        do_reset();
        #1 `CHK("irq_rst", 1'b0, bus.irq)
        issue(0, 8'h00, 4'hf, 0); issue(0, 8'h05, 4'hf, 0);
        drain();
        $display("test reset done");
        tally_and_finish();
    end
endmodule : onchip_bus_slave_port_read_bench
